/* hw/card_device_end.sv */
// card end of the host pin port: mode latch, decode, lanes, status pins
// assumes host pins are already synchronous to i_clk_sys
`timescale 1ns/10ps
module card_device_end (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_sys_rst,
  card_pin_if.device                 pins,
  output logic                       o_mode_valid,
  output card_pin_pkg::mode_e        o_mode,
  output logic                       o_acc_valid,
  output card_pin_pkg::region_e      o_acc_region,
  output logic [10:0]                o_acc_index,
  output logic                       o_acc_write,
  output logic [15:0]                o_acc_wdata,
  output logic [1:0]                 o_acc_lanes,
  input  wire logic [15:0]           i_rdata,
  input  wire logic                  i_card_ready,
  input  wire logic                  i_write_protect,
  input  wire logic                  i_alert_enable,
  input  wire logic                  i_alert_clear,
  output logic                       o_alert_pending,
  input  wire logic                  i_dma_enable,
  input  wire logic                  i_dma_pending,
  output logic                       o_dma_beat,
  output logic                       o_secondary_sel,
  input  wire logic                  i_disk_active,
  input  wire logic                  i_diag_passed,
  output logic                       o_peer_disk_active_secondary_present_n,
  output logic                       o_peer_pass_diagnostic_n
);
  import card_pin_pkg::*;

  mode_e       mode_q;
  logic        mode_valid_q;
  logic        act_q;
  logic        ack_q;
  logic        ready_q;
  logic        wp_q;
  logic        alert_q;
  logic        req_q;
  region_e     region_c;
  logic        rd_c;
  logic        wr_c;
  logic        swap_c;
  logic [1:0]  lanes_c;
  logic [10:0] index_c;
  logic        card_mode;
  logic        sel_even;
  logic        sel_odd;
  logic        dma_ack;
  logic        take;

  assign card_mode = (mode_q != mode_task);
  assign sel_even  = ~pins.ce1_n;
  assign sel_odd   = ~pins.odd_byte_chip_enable_n;
  // acknowledge only counts in task mode with dma on, so a floating
  // acknowledge from an old host does nothing
  assign dma_ack   = (mode_q == mode_task) & i_dma_enable
                     & ~pins.dma_acknowledge_n;
  assign take      = (rd_c | wr_c) & ~act_q;

  // mode caught on the first edge after reset release, never in reset
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      mode_valid_q <= 1'b0;
      mode_q       <= mode_mem;
    end else if (!mode_valid_q) begin
      mode_valid_q <= 1'b1;
      mode_q       <= pins.mode_sel;
    end
  end

  // address, strobe and lane decode per latched mode
  always_comb begin
    region_c = rgn_none;
    rd_c     = 1'b0;
    wr_c     = 1'b0;
    swap_c   = 1'b0;
    lanes_c  = LANE_WORD;
    index_c  = pins.addr;
    if (!mode_valid_q) begin
      region_c = rgn_none;
    end else if (card_mode) begin
      // odd byte can reach the low lane so 8-bit hosts work alone
      if (sel_even & sel_odd) begin
        lanes_c = LANE_WORD;
      end else if (sel_odd) begin
        lanes_c = LANE_ODD;
      end else begin
        lanes_c = pins.addr[0] ? LANE_ODD : LANE_EVEN;
        swap_c  = pins.addr[0];
      end
      if ((sel_even | sel_odd) & (~pins.oe_n | ~pins.we_n)) begin
        rd_c = ~pins.oe_n;
        wr_c = pins.oe_n;
        if (pins.attr_sel_n) begin
          region_c = rgn_mem_port;
        end else if (pins.addr >= CCR_BASE) begin
          region_c = rgn_ccr;
        end else begin
          region_c = rgn_cis;
        end
      end else if ((sel_even | sel_odd) & (mode_q == mode_io)
                   & (~pins.iord_n | ~pins.iowr_n)) begin
        rd_c     = ~pins.iord_n;
        wr_c     = pins.iord_n;
        region_c = rgn_io_port;
      end
    end else begin
      // write enable plays no part here; upper address lines dropped
      index_c = {8'h00, pins.addr[TASK_ADDR_W-1:0]};
      if (dma_ack & (~pins.iord_n | ~pins.iowr_n)) begin
        rd_c     = ~pins.iord_n;
        wr_c     = pins.iord_n;
        region_c = rgn_task;
        index_c  = TASK_DATA_IX;
        lanes_c  = LANE_WORD;
      end else if ((sel_even | sel_odd)
                   & (~pins.iord_n | ~pins.iowr_n)) begin
        rd_c     = ~pins.iord_n;
        wr_c     = pins.iord_n;
        region_c = sel_even ? rgn_task : rgn_task_alt;
        lanes_c  = (sel_even && index_c == TASK_DATA_IX)
                   ? LANE_WORD : LANE_EVEN;
      end
    end
  end

  // one access report per strobe, taken on its leading edge
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      act_q        <= 1'b0;
      o_acc_valid  <= 1'b0;
      o_acc_region <= rgn_none;
      o_acc_index  <= 11'h000;
      o_acc_write  <= 1'b0;
      o_acc_wdata  <= 16'h0000;
      o_acc_lanes  <= LANE_WORD;
    end else begin
      act_q       <= rd_c | wr_c;
      o_acc_valid <= take;
      if (take) begin
        o_acc_region <= region_c;
        o_acc_index  <= index_c;
        o_acc_write  <= wr_c;
        o_acc_lanes  <= lanes_c;
        // even byte kept in [7:0], odd byte in [15:8]
        o_acc_wdata  <= swap_c ? {pins.d_bus[7:0], 8'h00}
                                : pins.d_bus;
      end
    end
  end

  // read data steering; lanes outside the access stay released
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      pins.dev_d    <= 16'h0000;
      pins.dev_d_oe <= 2'h0;
    end else if (rd_c) begin
      pins.dev_d    <= swap_c ? {8'h00, i_rdata[15:8]} : i_rdata;
      pins.dev_d_oe <= swap_c ? LANE_EVEN : lanes_c;
    end else begin
      pins.dev_d_oe <= 2'h0;
    end
  end

  // request drops while acknowledged and returns once released
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      req_q      <= 1'b0;
      ack_q      <= 1'b0;
      o_dma_beat <= 1'b0;
    end else begin
      ack_q      <= dma_ack;
      o_dma_beat <= dma_ack & ~ack_q;
      if (!(mode_q == mode_task && i_dma_enable)) begin
        req_q <= 1'b0;
      end else if (dma_ack) begin
        req_q <= 1'b0;
      end else begin
        req_q <= i_dma_pending;
      end
    end
  end
  assign pins.dma_request_out = req_q;

  // status change capture; a new change beats a same-cycle clear
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ready_q <= i_card_ready;     // track in reset: no false change
      wp_q    <= i_write_protect;  // at release when the card is ready
      alert_q <= 1'b0;
    end else begin
      ready_q <= i_card_ready;
      wp_q    <= i_write_protect;
      if (mode_valid_q && mode_q == mode_io
          && (ready_q != i_card_ready || wp_q != i_write_protect)) begin
        alert_q <= 1'b1;
      end else if (i_alert_clear) begin
        alert_q <= 1'b0;
      end
    end
  end
  assign o_alert_pending = alert_q;

  // shared status pins by mode; released until the mode is known
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !mode_valid_q) begin
      pins.p45_dev_o  <= 1'b1;
      pins.p45_dev_oe <= 1'b0;
      pins.p46_dev_o  <= 1'b1;
      pins.p46_dev_oe <= 1'b0;
    end else begin
      case (mode_q)
        mode_mem: begin
          pins.p45_dev_o  <= 1'b1;
          pins.p45_dev_oe <= 1'b1;
          pins.p46_dev_o  <= 1'b1;
          pins.p46_dev_oe <= 1'b1;
        end
        mode_io: begin
          pins.p45_dev_o  <= 1'b1;
          pins.p45_dev_oe <= 1'b1;
          pins.p46_dev_o  <= ~(alert_q & i_alert_enable);
          pins.p46_dev_oe <= 1'b1;
        end
        mode_task: begin
          // open drain so the second drive can share both lines
          pins.p45_dev_o  <= 1'b0;
          pins.p45_dev_oe <= i_disk_active;
          pins.p46_dev_o  <= 1'b0;
          pins.p46_dev_oe <= i_diag_passed;
        end
        default: begin
          pins.p45_dev_oe <= 1'b0;
          pins.p46_dev_oe <= 1'b0;
        end
      endcase
    end
  end

  // drive role and peer handshake only mean anything in task mode
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_secondary_sel <= 1'b0;
      o_peer_disk_active_secondary_present_n     <= 1'b0;
      o_peer_pass_diagnostic_n    <= 1'b0;
    end else if (mode_valid_q && !card_mode) begin
      o_secondary_sel <= pins.drive_select_in;
      o_peer_disk_active_secondary_present_n     <= ~pins.p45;
      o_peer_pass_diagnostic_n    <= ~pins.p46;
    end else begin
      o_secondary_sel <= 1'b0;
      o_peer_disk_active_secondary_present_n     <= 1'b0;
      o_peer_pass_diagnostic_n    <= 1'b0;
    end
  end

  assign o_mode_valid = mode_valid_q;
  assign o_mode       = mode_q;

endmodule // card_device_end

/* hw/card_host_end.sv */
// host end: runs one strobed access or dma beat at a time on the pins
// assumes the card end shares i_clk_sys and the resolved pin bundle
`timescale 1ns/10ps
module card_host_end (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_sys_rst,
  card_pin_if.host                   pins,
  input  card_pin_pkg::mode_e        i_mode,
  input  wire logic                  i_req,
  input  wire logic                  i_req_write,
  input  card_pin_pkg::space_e       i_req_space,
  input  wire logic [10:0]           i_req_addr,
  input  wire logic [15:0]           i_req_wdata,
  input  wire logic [1:0]            i_req_lanes,
  input  wire logic                  i_use_dma,
  input  wire logic                  i_dma_read,
  input  wire logic                  i_drive_select,
  input  wire logic                  i_assert_disk_active_secondary_present_n,
  input  wire logic                  i_assert_pass_diagnostic_n,
  output logic                       o_busy,
  output logic                       o_done,
  output logic [15:0]                o_rdata,
  output logic                       o_alert,
  output logic                       o_battery_ok
);
  import card_pin_pkg::*;

  typedef enum logic [2:0] {
    st_idle,
    st_setup,
    st_strobe,
    st_hold
  } state_e;

  state_e            st_q;
  logic [CNT_W-1:0]  cnt_q;
  logic              rd_q;
  logic              task_m;

  assign task_m = (i_mode == mode_task);

  // transfer sequencer: setup, strobe low, release
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_q                     <= st_idle;
      cnt_q                    <= '0;
      rd_q                     <= 1'b0;
      o_busy                   <= 1'b0;
      o_done                   <= 1'b0;
      o_rdata                  <= 16'h0000;
      pins.addr                <= 11'h000;
      pins.attr_sel_n          <= 1'b1;
      pins.ce1_n               <= 1'b1;
      pins.odd_byte_chip_enable_n <= 1'b1;
      pins.oe_n                <= 1'b1;
      pins.we_n                <= 1'b1;
      pins.iord_n              <= 1'b1;
      pins.iowr_n              <= 1'b1;
      pins.dma_acknowledge_n   <= 1'b1;
      pins.host_d              <= 16'h0000;
      pins.host_d_oe           <= 2'h0;
    end else begin
      o_done <= 1'b0;
      case (st_q)
        st_idle: begin
          cnt_q <= CNT_W'(SETUP_CYC);
          if (task_m && i_use_dma && pins.dma_request_out) begin
            pins.dma_acknowledge_n <= 1'b0;
            rd_q           <= i_dma_read;
            pins.host_d    <= i_req_wdata;
            pins.host_d_oe <= i_dma_read ? 2'h0 : LANE_WORD;
            o_busy         <= 1'b1;
            st_q           <= st_setup;
          end else if (i_req) begin
            rd_q <= ~i_req_write;
            o_busy <= 1'b1;
            if (task_m) begin
              pins.addr <= {8'h00, i_req_addr[TASK_ADDR_W-1:0]};
              pins.ce1_n <= (i_req_space == sp_attr);
              pins.odd_byte_chip_enable_n <= (i_req_space != sp_attr);
              pins.host_d_oe <= i_req_write ? i_req_lanes : 2'h0;
            end else begin
              pins.addr       <= i_req_addr;
              pins.attr_sel_n <= (i_req_space == sp_common);
              pins.ce1_n      <= ~i_req_lanes[0];
              pins.odd_byte_chip_enable_n <= ~i_req_lanes[1];
              pins.host_d_oe  <= i_req_write ? i_req_lanes : 2'h0;
            end
            pins.host_d <= i_req_wdata;
            st_q        <= st_setup;
          end
        end
        st_setup: begin
          if (cnt_q > CNT_W'(1)) begin
            cnt_q <= cnt_q - CNT_W'(1);
          end else begin
            cnt_q <= CNT_W'(STROBE_CYC);
            if (task_m || i_req_space == sp_io) begin
              pins.iord_n <= ~rd_q;
              pins.iowr_n <= rd_q;
            end else begin
              pins.oe_n <= ~rd_q;
              pins.we_n <= rd_q;
            end
            st_q <= st_strobe;
          end
        end
        st_strobe: begin
          if (cnt_q > CNT_W'(1)) begin
            cnt_q <= cnt_q - CNT_W'(1);
          end else begin
            o_rdata     <= pins.d_bus;
            pins.oe_n   <= 1'b1;
            pins.we_n   <= 1'b1;
            pins.iord_n <= 1'b1;
            pins.iowr_n <= 1'b1;
            st_q        <= st_hold;
          end
        end
        st_hold: begin
          pins.ce1_n                  <= 1'b1;
          pins.odd_byte_chip_enable_n <= 1'b1;
          pins.attr_sel_n             <= 1'b1;
          pins.dma_acknowledge_n      <= 1'b1;
          pins.host_d_oe              <= 2'h0;
          o_busy                      <= 1'b0;
          o_done                      <= 1'b1;
          st_q                        <= st_idle;
        end
        default: st_q <= st_idle;
      endcase
    end
  end

  // mode and handshake pins; task mode lines are open drain
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      pins.mode_sel        <= mode_mem;
      pins.drive_select_in <= 1'b0;
      pins.p45_host_o      <= 1'b0;
      pins.p45_host_oe     <= 1'b0;
      pins.p46_host_o      <= 1'b0;
      pins.p46_host_oe     <= 1'b0;
      o_alert              <= 1'b0;
      o_battery_ok         <= 1'b0;
    end else begin
      pins.mode_sel <= i_mode;
      // may carry an upper address line in card modes; card ignores it
      pins.drive_select_in <= i_drive_select;
      pins.p45_host_oe <= task_m & i_assert_disk_active_secondary_present_n;
      pins.p46_host_oe <= task_m & i_assert_pass_diagnostic_n;
      o_alert      <= (i_mode == mode_io) & ~pins.p46;
      o_battery_ok <= (i_mode == mode_mem) & pins.p45 & pins.p46;
    end
  end

endmodule // card_host_end

/* hw/card_pin_if.sv */
// pin bundle between the card end and the host end
// resolves shared data and open-drain status pins from the enables
`timescale 1ns/10ps
interface card_pin_if;
  import card_pin_pkg::*;

  mode_e        mode_sel;
  logic [10:0]  addr;
  logic         attr_sel_n;
  logic         ce1_n;
  logic         odd_byte_chip_enable_n;
  logic         oe_n;
  logic         we_n;
  logic         iord_n;
  logic         iowr_n;
  logic         drive_select_in;
  logic         dma_acknowledge_n;
  logic         dma_request_out;
  logic [15:0]  host_d;
  logic [1:0]   host_d_oe;
  logic [15:0]  dev_d;
  logic [1:0]   dev_d_oe;
  logic         p45_dev_o;
  logic         p45_dev_oe;
  logic         p46_dev_o;
  logic         p46_dev_oe;
  logic         p45_host_o;
  logic         p45_host_oe;
  logic         p46_host_o;
  logic         p46_host_oe;
  logic [15:0]  d_bus;
  logic         p45;
  logic         p46;

  // undriven lanes read as zero; status pins pull high when released
  genvar b;
  for (b = 0; b < 2; b++) begin : g_lane
    assign d_bus[b*8 +: 8] = dev_d_oe[b]  ? dev_d[b*8 +: 8]  :
                             host_d_oe[b] ? host_d[b*8 +: 8] : 8'h00;
  end
  assign p45 = ~((p45_dev_oe & ~p45_dev_o) | (p45_host_oe & ~p45_host_o));
  assign p46 = ~((p46_dev_oe & ~p46_dev_o) | (p46_host_oe & ~p46_host_o));

  modport device (
    input  mode_sel, addr, attr_sel_n, ce1_n, odd_byte_chip_enable_n,
    input  oe_n, we_n, iord_n, iowr_n, drive_select_in,
    input  dma_acknowledge_n, d_bus, p45, p46,
    output dma_request_out, dev_d, dev_d_oe,
    output p45_dev_o, p45_dev_oe, p46_dev_o, p46_dev_oe
  );

  modport host (
    input  dma_request_out, d_bus, p45, p46,
    output mode_sel, addr, attr_sel_n, ce1_n, odd_byte_chip_enable_n,
    output oe_n, we_n, iord_n, iowr_n, drive_select_in,
    output dma_acknowledge_n, host_d, host_d_oe,
    output p45_host_o, p45_host_oe, p46_host_o, p46_host_oe
  );
endinterface

/* hw/card_pin_pkg.sv */
// shared constants and types for the card host-pin logic
// assumes both ends run on one 25 MHz clock with a synchronous reset
package card_pin_pkg;

  // operating mode of the card and the role of its multiplexed pins
  typedef enum logic [1:0] {
    mode_mem,
    mode_io,
    mode_task
  } mode_e;

  // address space that a decoded access lands in
  typedef enum logic [2:0] {
    rgn_none,
    rgn_cis,
    rgn_ccr,
    rgn_mem_port,
    rgn_io_port,
    rgn_task,
    rgn_task_alt
  } region_e;

  // address space the host asks for
  typedef enum logic [1:0] {
    sp_attr,
    sp_common,
    sp_io
  } space_e;

  localparam int          ADDR_W       = 11;
  localparam int          DATA_W       = 16;
  localparam int          TASK_ADDR_W  = 3;
  localparam int          TASK_REGS    = 8;
  // attribute offsets at or above this index reach the config registers
  localparam logic [10:0] CCR_BASE     = 11'h200;
  localparam logic [10:0] TASK_DATA_IX = 11'h000;
  localparam logic [1:0]  LANE_EVEN    = 2'h1;
  localparam logic [1:0]  LANE_ODD     = 2'h2;
  localparam logic [1:0]  LANE_WORD    = 2'h3;

  // host strobe timing
  localparam int CLK_NS     = 40;
  localparam int SETUP_NS   = 30;
  localparam int STROBE_NS  = 120;
  localparam int SETUP_CYC  = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W      = 3;

endpackage

/* verification/card_host_pin_function_logic_test.sv */
// bench: host end and card end joined by the pin bundle, with a checker
// assumes the design files are compiled first
`timescale 1ns/10ps
module card_host_pin_function_logic_test;
  import card_pin_pkg::*;
  logic        i_clk_sys = 1'b0;
  logic        rst_h = 1'b1;
  logic        rst_d = 1'b1;
  integer      seed = 32'hea4e;
  integer      err_count = 0;
  integer      samples_checked = 0;
  integer      acc_n = 0;
  integer      beats = 0;
  mode_e       m_mode, mo;
  space_e      sp;
  region_e     ar;
  logic [10:0] ra, a, ai;
  logic [15:0] wd, rdata, awd, hrd;
  logic [1:0]  lanes, al;
  logic        req, req_wr, use_dma, dsel, a_disk_active_secondary_present_n, a_pass_diagnostic_n, rdy, wp;
  logic        al_en, al_clr, dma_en, dma_pend, act, diag, mv, av, aw;
  logic        al_p, beat, ssel, pdasp, ppdiag, busy, done, h_al, batt;
  logic        dma_rd;

  card_pin_if pins ();
  card_device_end u_card_device_end (.i_clk_sys(i_clk_sys), .i_sys_rst(rst_d),
    .pins(pins), .o_mode_valid(mv), .o_mode(mo), .o_acc_valid(av),
    .o_acc_region(ar), .o_acc_index(ai), .o_acc_write(aw),
    .o_acc_wdata(awd), .o_acc_lanes(al), .i_rdata(rdata),
    .i_card_ready(rdy), .i_write_protect(wp), .i_alert_enable(al_en),
    .i_alert_clear(al_clr), .o_alert_pending(al_p), .i_dma_enable(dma_en),
    .i_dma_pending(dma_pend), .o_dma_beat(beat), .o_secondary_sel(ssel),
    .i_disk_active(act), .i_diag_passed(diag), .o_peer_disk_active_secondary_present_n(pdasp),
    .o_peer_pass_diagnostic_n(ppdiag));
  card_host_end u_card_host_end (.i_clk_sys(i_clk_sys), .i_sys_rst(rst_h),
    .pins(pins), .i_mode(m_mode), .i_req(req), .i_req_write(req_wr),
    .i_req_space(sp), .i_req_addr(ra), .i_req_wdata(wd),
    .i_req_lanes(lanes), .i_use_dma(use_dma), .i_dma_read(dma_rd),
    .i_drive_select(dsel), .i_assert_disk_active_secondary_present_n(a_disk_active_secondary_present_n),
    .i_assert_pass_diagnostic_n(a_pass_diagnostic_n), .o_busy(busy), .o_done(done),
    .o_rdata(hrd), .o_alert(h_al), .o_battery_ok(batt));
  card_pin_monitor u_mon (.i_clk_sys(i_clk_sys), .i_sys_rst(rst_d),
    .mode_sel(pins.mode_sel), .addr(pins.addr), .ce1_n(pins.ce1_n),
    .odd_byte_chip_enable_n(pins.odd_byte_chip_enable_n),
    .oe_n(pins.oe_n), .iord_n(pins.iord_n),
    .dma_acknowledge_n(pins.dma_acknowledge_n),
    .dma_request_out(pins.dma_request_out), .dev_d_oe(pins.dev_d_oe),
    .p45(pins.p45), .p46(pins.p46), .p45_dev_oe(pins.p45_dev_oe),
    .p46_dev_oe(pins.p46_dev_oe));

  always #20 i_clk_sys = ~i_clk_sys;
  // event counts for the reference model
  always @(posedge i_clk_sys) begin
    if (av === 1'b1) acc_n++;
    if (beat === 1'b1) beats++;
  end

  task automatic chk_v(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, input logic e);
    chk_v({15'h0, g}, {15'h0, e});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  // card mode is latched once, so the card leaves reset after the host
  task automatic start(input mode_e m);
    m_mode = m;
    rst_h = 1'b1;
    rst_d = 1'b1;
    tick(3);
    rst_h = 1'b0;
    tick(2);
    rst_d = 1'b0;
    tick(3);
  endtask
  // reference decode of one access
  function automatic region_e exp_reg(input space_e s, input logic [10:0] x);
    if (m_mode == mode_task) return (s == sp_attr) ? rgn_task_alt : rgn_task;
    if (s == sp_io) return rgn_io_port;
    if (s == sp_common) return rgn_mem_port;
    return (x >= CCR_BASE) ? rgn_ccr : rgn_cis;
  endfunction
  // one host access, then the card side and the read word are compared
  task automatic acc(input logic w, input space_e s, input logic [10:0] x,
                     input logic [1:0] l);
    integer n, k;
    logic [15:0] m;
    logic [10:0] ei;
    logic sw;
    n = acc_n;
    k = 0;
    m = (l == 2'h3) ? 16'hFFFF : (l == 2'h2) ? 16'hFF00 : 16'h00FF;
    // even select with an odd address moves the odd byte onto D7:0
    sw = (m_mode != mode_task) && (l == 2'h1) && x[0];
    ei = (m_mode == mode_task) ? {8'h00, x[2:0]} : x;
    wd = 16'($random(seed));
    rdata = 16'($random(seed));
    sp = s;
    {req_wr, ra, lanes, req} = {w, x, l, 1'b1};
    tick(1);
    req = 1'b0;
    while (done !== 1'b1 && k < 20) begin
      tick(1);
      k++;
    end
    if (k == 20) begin
      err_count++;
      $display("[ERR] %0t access never completed", $time);
    end
    chk_v(16'(acc_n - n), 16'h1);
    chk_b(aw, w);
    chk_v(16'(ar), 16'(exp_reg(s, x)));
    chk_v({5'h00, ai}, {5'h00, ei});
    chk_v({14'h0, al}, {14'h0, sw ? 2'h2 : l});
    if (w && sw) chk_v(awd & 16'hFF00, {wd[7:0], 8'h00});
    else if (w) chk_v(awd & m, wd & m);
    else if (sw) chk_v(hrd & m, {8'h00, rdata[15:8]});
    else chk_v(hrd & m, rdata & m);
  endtask

  initial begin
    {req, req_wr, use_dma, dsel, a_disk_active_secondary_present_n, a_pass_diagnostic_n, rdy, wp} = 8'h00;
    {al_en, al_clr, dma_en, dma_pend, act, diag} = 6'h00;
    {ra, wd, rdata, lanes} = 45'h0;
    sp = sp_common;
    m_mode = mode_mem;
    dma_rd = 1'b1;
    start(mode_mem);
    dsel = 1'b1;
    tick(3);
    chk_b(ssel, 1'b0);
    chk_b(batt, 1'b1);
    chk_v({14'h0, pins.p45_dev_oe, pins.p45_dev_o}, 16'h3);
    chk_v({14'h0, pins.p46_dev_oe, pins.p46_dev_o}, 16'h3);
    for (int i = 0; i < 6; i++) begin
      a = 11'($random(seed));
      a[0] = 1'b0;
      acc(i[0], (i < 4) ? sp_common : sp_attr, a, (i == 2) ? 2'h1 : 2'h3);
    end
    for (int i = 0; i < 4; i++) begin
      acc(i[0], sp_common, {10'h052, i[1]}, {~i[1], i[1]});
    end
    start(mode_io);
    chk_v({14'h0, pins.p45_dev_oe, pins.p45_dev_o}, 16'h3);
    for (int i = 0; i < 4; i++) acc(i[0], sp_io, 11'($random(seed)), 2'h3);
    al_en = 1'b1;
    rdy = 1'b1;
    tick(4);
    chk_b(al_p, 1'b1);
    chk_b(h_al, 1'b1);
    al_clr = 1'b1;
    tick(2);
    al_clr = 1'b0;
    al_en = 1'b0;
    tick(2);
    chk_b(al_p, 1'b0);
    wp = 1'b1;
    tick(4);
    chk_b(al_p, 1'b1);
    chk_b(h_al, 1'b0);
    start(mode_task);
    chk_b(ssel, 1'b1);
    // upper address lines stay grounded by the host side
    for (int i = 0; i < 8; i++) acc(!i[0], sp_common, 11'(i),
      (i == 0) ? 2'h3 : 2'h1);
    acc(1'b0, sp_attr, 11'h006, 2'h1);
    dma_pend = 1'b1;
    use_dma = 1'b1;
    tick(10);
    chk_b(pins.dma_request_out, 1'b0);
    chk_b(pins.dma_acknowledge_n, 1'b1);
    dma_en = 1'b1;
    tick(40);
    dma_pend = 1'b0;
    tick(20);
    chk_b(beats > 1, 1'b1);
    chk_v(hrd, rdata);
    chk_b(pins.dma_request_out, 1'b0);
    // write beats: the whole word reaches the card side
    dma_rd = 1'b0;
    wd = 16'($random(seed));
    dma_pend = 1'b1;
    tick(8);
    dma_pend = 1'b0;
    tick(20);
    chk_v(awd, wd);
    chk_b(aw, 1'b1);
    // card pulls both lines alone, then only the host does
    {act, diag} = 2'h3;
    tick(3);
    chk_v({14'h0, pins.p45, pins.p46}, 16'h0);
    {act, diag, a_disk_active_secondary_present_n, a_pass_diagnostic_n} = 4'h3;
    tick(4);
    chk_v({12'h0, pdasp, ppdiag, pins.p45, pins.p46}, 16'hC);
    test_done();
  end
  initial begin
    #(40 * 5000);
    err_count++;
    test_done();
  end
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
endmodule // card_host_pin_function_logic_test

/* verification/card_pin_monitor.sv */
// checker on the pin bundle between the card end and the host end
// assumes one clock; reset is the card end's reset
`timescale 1ns/10ps
module card_pin_monitor (
  input wire logic           i_clk_sys,
  input wire logic           i_sys_rst,
  input card_pin_pkg::mode_e mode_sel,
  input wire logic [10:0]    addr,
  input wire logic           ce1_n,
  input wire logic           odd_byte_chip_enable_n,
  input wire logic           oe_n,
  input wire logic           iord_n,
  input wire logic           dma_acknowledge_n,
  input wire logic           dma_request_out,
  input wire logic [1:0]     dev_d_oe,
  input wire logic           p45,
  input wire logic           p46,
  input wire logic           p45_dev_oe,
  input wire logic           p46_dev_oe
);
  import card_pin_pkg::*;
  logic [1:0] up_q;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // status pins are only driven from the second edge after release
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  // a read strobe seen low on two edges in a row
  sequence io_rd; !iord_n ##1 !iord_n; endsequence
  sequence mem_rd; !oe_n ##1 !oe_n; endsequence
  batt_pins_a:
    assert property (up_q == 2'h3 && mode_sel == mode_mem
      |-> p45 && p46 && p45_dev_oe && p46_dev_oe)
    else $error("battery pins not high");
  audio_high_a:
    assert property (up_q == 2'h3 && mode_sel == mode_io
      |-> p45 && p45_dev_oe)
    else $error("audio pin not high");
  req_mode_a:
    assert property (mode_sel != mode_task |-> !dma_request_out)
    else $error("dma request outside task mode");
  req_drop_a:
    assert property (dma_request_out && !dma_acknowledge_n
      |=> !dma_request_out)
    else $error("dma request kept after acknowledge");
  req_held_a:
    assert property (!dma_acknowledge_n ##1 !dma_acknowledge_n
      |-> !dma_request_out)
    else $error("dma request during acknowledge");
  task_byte_a:
    assert property (io_rd ##0 (mode_sel == mode_task && !ce1_n &&
      addr[2:0] != 3'h0) |-> dev_d_oe == 2'h1)
    else $error("task register read not on low byte");
  word_data_a:
    assert property (io_rd ##0 (mode_sel == mode_task && !ce1_n &&
      addr[2:0] == 3'h0) |-> dev_d_oe == 2'h3)
    else $error("data read not a full word");
  byte_lane_a:
    assert property (mem_rd ##0 (mode_sel == mode_mem && !ce1_n &&
      odd_byte_chip_enable_n) |-> dev_d_oe == 2'h1)
    else $error("even byte read not on low lane");
endmodule // card_pin_monitor
